// File: igc_pkg.sv
// constants, timing counts and state encodings for the two-wire bus ends
// assumes a 250 MHz system clock; all times are turned into cycle counts here
package igc_pkg;

  // system clock period
  localparam int CLK_NS = 4;
  // timer width in bits
  localparam int TW = 12;

  // bus timing, standard mode then fast mode, in ns
  localparam int SM_PERIOD_NS = 10000; // 100 kHz
  localparam int FM_PERIOD_NS = 2500; // 400 kHz
  localparam int SM_BUF_NS = 4700;
  localparam int FM_BUF_NS = 1300;
  localparam int SM_HDSTA_NS = 4000;
  localparam int FM_HDSTA_NS = 600;
  localparam int SM_LOW_NS = 4700;
  localparam int FM_LOW_NS = 1300;
  localparam int SM_HIGH_NS = 4000;
  localparam int FM_HIGH_NS = 600;
  localparam int SM_SUSTA_NS = 4700;
  localparam int FM_SUSTA_NS = 600;
  localparam int SM_SUSTO_NS = 4000;
  localparam int FM_SUSTO_NS = 600;
  localparam int HDDAT_NS = 300; // internal data hold after scl fall
  localparam int FM_HDDAT_MAX_NS = 900;
  localparam int SPIKE_NS = 50;

  // least times round up to whole cycles
  function automatic int upCyc(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction

  // low phase also stretched so that low plus high meets the mode's period
  function automatic int lowNs(input int lowMin, input int period, input int high);
    return (period - high > lowMin) ? period - high : lowMin;
  endfunction

  localparam logic [TW-1:0] SM_BUF_CYC = TW'(upCyc(SM_BUF_NS));
  localparam logic [TW-1:0] FM_BUF_CYC = TW'(upCyc(FM_BUF_NS));
  localparam logic [TW-1:0] SM_HDSTA_CYC = TW'(upCyc(SM_HDSTA_NS));
  localparam logic [TW-1:0] FM_HDSTA_CYC = TW'(upCyc(FM_HDSTA_NS));
  localparam logic [TW-1:0] SM_LOW_CYC = TW'(upCyc(lowNs(SM_LOW_NS, SM_PERIOD_NS, SM_HIGH_NS)));
  localparam logic [TW-1:0] FM_LOW_CYC = TW'(upCyc(lowNs(FM_LOW_NS, FM_PERIOD_NS, FM_HIGH_NS)));
  localparam logic [TW-1:0] SM_HIGH_CYC = TW'(upCyc(SM_HIGH_NS));
  localparam logic [TW-1:0] FM_HIGH_CYC = TW'(upCyc(FM_HIGH_NS));
  localparam logic [TW-1:0] SM_SUSTA_CYC = TW'(upCyc(SM_SUSTA_NS));
  localparam logic [TW-1:0] FM_SUSTA_CYC = TW'(upCyc(FM_SUSTA_NS));
  localparam logic [TW-1:0] SM_SUSTO_CYC = TW'(upCyc(SM_SUSTO_NS));
  localparam logic [TW-1:0] FM_SUSTO_CYC = TW'(upCyc(FM_SUSTO_NS));
  // hold is the least of 300 ns rounded up and the fast-mode ceiling rounded down
  localparam logic [TW-1:0] HDDAT_CYC = TW'((upCyc(HDDAT_NS) < FM_HDDAT_MAX_NS / CLK_NS) ?
                                             upCyc(HDDAT_NS) : FM_HDDAT_MAX_NS / CLK_NS);
  localparam logic [TW-1:0] TMR_ONE = TW'(1);
  localparam logic [3:0] SPIKE_CYC = 4'(upCyc(SPIKE_NS));

  // byte values and field layout
  localparam logic [7:0] GCALL_BYTE = 8'h00;
  localparam logic [7:0] STARTB_BYTE = 8'h01;
  localparam logic [4:0] TENBIT_PFX = 5'h1E; // 11110
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_ADDR2 = 3'b010,
    S_GC1 = 3'b011,
    S_GC2 = 3'b100,
    S_WRITE = 3'b101,
    S_READ = 3'b110
  } igc_sst_t;

  typedef enum logic [3:0] {
    M_BUF = 4'b0000,
    M_IDLE = 4'b0001,
    M_START = 4'b0010,
    M_LOW = 4'b0011,
    M_HIGH = 4'b0100,
    M_WAIT = 4'b0101,
    M_RSSU = 4'b0110,
    M_STOP1 = 4'b0111,
    M_STOP2 = 4'b1000
  } igc_mst_t;

endpackage

// File: igc_bus_if.sv
// shared two-wire bus between the master end and the slave end
// assumes open-drain drivers: an end pulls a line low only while its enable is low
`timescale 1ns/100ps
interface igc_bus_if;
  logic mSclO;
  logic mSclOeN;
  logic mSdaO;
  logic mSdaOeN;
  logic sSclO;
  logic sSclOeN;
  logic sSdaO;
  logic sSdaOeN;
  logic scl;
  logic sda;

  // wired-and of both ends with pull-up
  assign scl = !((!mSclOeN && !mSclO) || (!sSclOeN && !sSclO));
  assign sda = !((!mSdaOeN && !mSdaO) || (!sSdaOeN && !sSdaO));

  modport master (
    input scl,
    input sda,
    output mSclO,
    output mSclOeN,
    output mSdaO,
    output mSdaOeN
  );

  modport slave (
    input scl,
    input sda,
    output sSclO,
    output sSclOeN,
    output sSdaO,
    output sSdaOeN
  );
endinterface

// File: igc_slave.sv
// device end: addressed slave with general call, 10-bit addressing and rx buffer
// assumes bus lines arrive asynchronously and user side runs on clk
//
// Overview of operation
// - 10-bit slave answers general call like 7-bit
// - general call may carry master's 10-bit address
// - first byte after call holds address LSBs
// - start byte ahead of addressing is ignored
// - keep up or stretch scl low
// - scl never above 100 or 400 kHz
// - bus free time before next start
// - hold start before first clock pulse
// - minimum scl low and high phases
// - scl high setup before repeated start
// - data hold after scl fall, bounded
// - scl high setup before stop
// - start or repeated start resets protocol
// - 10-bit first byte is 11110, msbs, rw
// - filter suppresses spikes up to 50 ns
`timescale 1ns/100ps
module igc_slave (
  input wire logic clk,
  input wire logic reset,
  igc_bus_if.slave bus,
  input wire logic fastMode,
  input wire logic tenBit,
  input wire logic [9:0] ownAddr,
  input wire logic [7:0] txByte,
  output logic [7:0] rxData,
  output logic rxValid,
  input wire logic rxReady,
  output logic [9:0] mstAddr,
  output logic mstAddrValid
);

  logic [1:0] rawIn;
  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic [1:0] filt_r;
  logic [3:0] fcnt_r [2];
  logic sclD_r;
  logic sdaD_r;
  logic sclF;
  logic sdaF;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  igc_pkg::igc_sst_t state_r;
  igc_pkg::igc_sst_t byteNext;
  logic byteAck;
  logic [3:0] bitCnt_r;
  logic [7:0] shift_r;
  logic [7:0] txSh_r;
  logic tenSel_r;
  logic pendLow_r;
  logic [igc_pkg::TW-1:0] holdCnt_r;
  logic sdaOeN_r;
  logic sclOeN_r;
  logic pushPend_r;
  logic [7:0] pushData_r;
  logic push;
  logic pop;
  logic [7:0] spare_r;
  logic spareV_r;
  logic [7:0] rxData_r;
  logic rxValid_r;
  logic [7:0] mstLo_r;
  logic [9:0] mstAddr_r;
  logic mstAddrValid_r;
  logic isGc;
  logic isStartB;
  logic tenHit;
  logic sevenHit;
  logic rwBit;

  assign rawIn = {bus.scl, bus.sda};

  // two-flop sync then spike filter per line
  generate
    for (genvar i = 0; i < 2; i++) begin : g_filt
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          meta_r[i] <= 1'b1;
          sync_r[i] <= 1'b1;
          filt_r[i] <= 1'b1;
          fcnt_r[i] <= 4'h0;
        end else begin
          meta_r[i] <= rawIn[i];
          sync_r[i] <= meta_r[i];
          if (sync_r[i] == filt_r[i]) begin
            fcnt_r[i] <= 4'h0;
          end else if (fcnt_r[i] == igc_pkg::SPIKE_CYC) begin
            filt_r[i] <= sync_r[i];
            fcnt_r[i] <= 4'h0;
          end else begin
            fcnt_r[i] <= fcnt_r[i] + 4'h1;
          end
        end
      end
    end
  endgenerate

  // line edges and bus conditions
  assign sclF = filt_r[1];
  assign sdaF = filt_r[0];
  assign sclRise = sclF && !sclD_r;
  assign sclFall = !sclF && sclD_r;
  assign startDet = sclF && sclD_r && sdaD_r && !sdaF;
  assign stopDet = sclF && sclD_r && !sdaD_r && sdaF;

  // address byte decode
  assign isGc = shift_r == igc_pkg::GCALL_BYTE;
  assign isStartB = shift_r == igc_pkg::STARTB_BYTE;
  assign tenHit = tenBit && shift_r[7:3] == igc_pkg::TENBIT_PFX && shift_r[2:1] == ownAddr[9:8];
  assign sevenHit = !tenBit && shift_r[7:1] == ownAddr[6:0];
  assign rwBit = shift_r[0];

  // buffer handshake
  assign push = pushPend_r && !spareV_r;
  assign pop = rxValid_r && rxReady;

  // decision taken when a whole byte is in
  always_comb begin
    byteAck = 1'b0;
    byteNext = igc_pkg::S_IDLE;
    case (state_r)
      igc_pkg::S_ADDR: begin
        // general call answered in either mode
        if (isGc) begin
          byteAck = 1'b1;
          byteNext = igc_pkg::S_GC1;
        end else if (isStartB) begin
          byteNext = igc_pkg::S_IDLE;
        end else if (tenHit && !rwBit) begin
          byteAck = 1'b1;
          byteNext = igc_pkg::S_ADDR2;
        end else if (tenHit && tenSel_r) begin
          byteAck = 1'b1;
          byteNext = igc_pkg::S_READ;
        end else if (sevenHit) begin
          byteAck = 1'b1;
          byteNext = rwBit ? igc_pkg::S_READ : igc_pkg::S_WRITE;
        end
      end
      igc_pkg::S_ADDR2: begin
        byteAck = shift_r == ownAddr[7:0];
        byteNext = byteAck ? igc_pkg::S_WRITE : igc_pkg::S_IDLE;
      end
      igc_pkg::S_GC1: begin
        byteAck = 1'b1;
        byteNext = igc_pkg::S_GC2;
      end
      igc_pkg::S_GC2, igc_pkg::S_WRITE: begin
        byteAck = 1'b1;
        byteNext = igc_pkg::S_WRITE;
      end
      igc_pkg::S_READ: begin
        byteNext = igc_pkg::S_READ;
      end
      default: begin
        byteNext = igc_pkg::S_IDLE;
      end
    endcase
  end

  // protocol engine
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
      state_r <= igc_pkg::S_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      txSh_r <= 8'h00;
      tenSel_r <= 1'b0;
      pendLow_r <= 1'b0;
      holdCnt_r <= '0;
      sdaOeN_r <= 1'b1;
      pushPend_r <= 1'b0;
      pushData_r <= 8'h00;
      mstLo_r <= 8'h00;
      mstAddr_r <= 10'h000;
      mstAddrValid_r <= 1'b0;
    end else begin
      sclD_r <= sclF;
      sdaD_r <= sdaF;
      mstAddrValid_r <= 1'b0;
      if (push) begin
        pushPend_r <= 1'b0;
      end
      // sda changes only after the hold count
      if (holdCnt_r != '0) begin
        holdCnt_r <= holdCnt_r - igc_pkg::TMR_ONE;
      end
      if (holdCnt_r == igc_pkg::TMR_ONE) begin
        sdaOeN_r <= !pendLow_r;
      end
      if (startDet) begin
        state_r <= igc_pkg::S_ADDR;
        bitCnt_r <= 4'h0;
        holdCnt_r <= '0;
        sdaOeN_r <= 1'b1;
      end else if (stopDet) begin
        state_r <= igc_pkg::S_IDLE;
        tenSel_r <= 1'b0;
        holdCnt_r <= '0;
        sdaOeN_r <= 1'b1;
      end else if (sclRise) begin
        if (bitCnt_r < igc_pkg::BYTE_BITS) begin
          shift_r <= {shift_r[6:0], sdaF};
          bitCnt_r <= bitCnt_r + 4'h1;
        end else begin
          bitCnt_r <= 4'h0;
          if (state_r == igc_pkg::S_READ && sdaF) begin
            state_r <= igc_pkg::S_IDLE; // master refused more data
          end
        end
      end else if (sclFall) begin
        holdCnt_r <= igc_pkg::HDDAT_CYC;
        if (bitCnt_r == igc_pkg::BYTE_BITS) begin
          state_r <= byteNext;
          pendLow_r <= byteAck;
          if (byteNext == igc_pkg::S_READ) begin
            txSh_r <= txByte;
          end
          if (state_r == igc_pkg::S_ADDR) begin
            tenSel_r <= tenSel_r && tenHit && rwBit;
          end
          if (state_r == igc_pkg::S_ADDR2) begin
            tenSel_r <= byteAck;
          end
          // byte parked until buffer has room
          if (state_r == igc_pkg::S_WRITE) begin
            pushPend_r <= 1'b1;
            pushData_r <= shift_r;
          end
          if (state_r == igc_pkg::S_GC1) begin
            mstLo_r <= shift_r;
          end
          if (state_r == igc_pkg::S_GC2) begin
            mstAddr_r <= {shift_r[1:0], mstLo_r};
            mstAddrValid_r <= 1'b1;
          end
        end else if (state_r == igc_pkg::S_READ) begin
          pendLow_r <= !txSh_r[7];
          txSh_r <= {txSh_r[6:0], 1'b0};
        end else begin
          pendLow_r <= 1'b0;
        end
      end
    end
  end

  // two-entry receive buffer and clock stretch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxData_r <= 8'h00;
      rxValid_r <= 1'b0;
      spare_r <= 8'h00;
      spareV_r <= 1'b0;
      sclOeN_r <= 1'b1;
    end else begin
      // hold scl low while a byte cannot be stored
      sclOeN_r <= !(pushPend_r && !push);
      if (pop && spareV_r) begin
        rxData_r <= spare_r;
        spare_r <= pushData_r;
        spareV_r <= push;
      end else if (pop) begin
        rxData_r <= pushData_r;
        rxValid_r <= push;
      end else if (push && rxValid_r) begin
        spare_r <= pushData_r;
        spareV_r <= 1'b1;
      end else if (push) begin
        rxData_r <= pushData_r;
        rxValid_r <= 1'b1;
      end
    end
  end

  // outputs
  assign bus.sSclO = 1'b0;
  assign bus.sSdaO = 1'b0;
  assign bus.sSclOeN = sclOeN_r;
  assign bus.sSdaOeN = sdaOeN_r;
  assign rxData = rxData_r;
  assign rxValid = rxValid_r;
  assign mstAddr = mstAddr_r;
  assign mstAddrValid = mstAddrValid_r;

endmodule

// File: igc_master.sv
// other end: bus master that sends bytes with start, repeated start and stop
// assumes a single master on the bus; user commands come from logic on clk
`timescale 1ns/100ps
module igc_master (
  input wire logic clk,
  input wire logic reset,
  igc_bus_if.master bus,
  input wire logic fastMode,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [7:0] cmdByte,
  input wire logic cmdStart,
  input wire logic cmdStop,
  output logic ackValid,
  output logic ackOk,
  output logic busy
);

  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic sclS;
  logic sdaS;
  igc_pkg::igc_mst_t state_r;
  logic [igc_pkg::TW-1:0] tmr_r;
  logic [3:0] bit_r;
  logic [7:0] byte_r;
  logic stop_r;
  logic sclOeN_r;
  logic sdaOeN_r;
  logic cmdReady_r;
  logic ackValid_r;
  logic ackOk_r;
  logic busy_r;
  logic tmrDone;
  logic take;
  logic bitLow;
  logic [igc_pkg::TW-1:0] bufCyc;
  logic [igc_pkg::TW-1:0] hdStaCyc;
  logic [igc_pkg::TW-1:0] lowCyc;
  logic [igc_pkg::TW-1:0] highCyc;
  logic [igc_pkg::TW-1:0] suStaCyc;
  logic [igc_pkg::TW-1:0] suStoCyc;
  logic [igc_pkg::TW-1:0] dataAt;

  assign bufCyc = fastMode ? igc_pkg::FM_BUF_CYC : igc_pkg::SM_BUF_CYC;
  assign hdStaCyc = fastMode ? igc_pkg::FM_HDSTA_CYC : igc_pkg::SM_HDSTA_CYC;
  // low phase sized to cap scl rate
  assign lowCyc = fastMode ? igc_pkg::FM_LOW_CYC : igc_pkg::SM_LOW_CYC;
  assign highCyc = fastMode ? igc_pkg::FM_HIGH_CYC : igc_pkg::SM_HIGH_CYC;
  assign suStaCyc = fastMode ? igc_pkg::FM_SUSTA_CYC : igc_pkg::SM_SUSTA_CYC;
  assign suStoCyc = fastMode ? igc_pkg::FM_SUSTO_CYC : igc_pkg::SM_SUSTO_CYC;
  // data moves a hold time after scl fall
  assign dataAt = lowCyc - igc_pkg::HDDAT_CYC;

  // decode
  assign sclS = sync_r[1];
  assign sdaS = sync_r[0];
  assign tmrDone = tmr_r == '0;
  assign take = cmdValid && cmdReady_r;
  assign bitLow = bit_r != igc_pkg::BYTE_BITS && !byte_r[7];

  // two-flop sync of bus lines
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= 2'h3;
      sync_r <= 2'h3;
    end else begin
      meta_r <= {bus.scl, bus.sda};
      sync_r <= meta_r;
    end
  end

  // bit and condition sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= igc_pkg::M_BUF;
      tmr_r <= igc_pkg::SM_BUF_CYC;
      bit_r <= 4'h0;
      byte_r <= 8'h00;
      stop_r <= 1'b0;
      sclOeN_r <= 1'b1;
      sdaOeN_r <= 1'b1;
      cmdReady_r <= 1'b0;
      ackValid_r <= 1'b0;
      ackOk_r <= 1'b0;
      busy_r <= 1'b1;
    end else begin
      ackValid_r <= 1'b0;
      cmdReady_r <= 1'b0;
      busy_r <= state_r != igc_pkg::M_IDLE;
      if (!tmrDone) begin
        tmr_r <= tmr_r - igc_pkg::TMR_ONE;
      end
      case (state_r)
        igc_pkg::M_BUF: begin
          if (tmrDone) begin
            state_r <= igc_pkg::M_IDLE;
          end
        end
        igc_pkg::M_IDLE: begin
          if (take) begin
            byte_r <= cmdByte;
            stop_r <= cmdStop;
            sdaOeN_r <= 1'b0;
            tmr_r <= hdStaCyc;
            state_r <= igc_pkg::M_START;
          end else begin
            cmdReady_r <= sclS && sdaS;
          end
        end
        igc_pkg::M_START: begin
          if (tmrDone) begin
            sclOeN_r <= 1'b0;
            tmr_r <= lowCyc;
            bit_r <= 4'h0;
            state_r <= igc_pkg::M_LOW;
          end
        end
        igc_pkg::M_LOW: begin
          if (tmr_r <= dataAt) begin
            sdaOeN_r <= !bitLow;
          end
          if (tmrDone) begin
            sclOeN_r <= 1'b1;
            tmr_r <= highCyc;
            state_r <= igc_pkg::M_HIGH;
          end
        end
        // high phase counted once scl seen high
        igc_pkg::M_HIGH: begin
          if (!sclS) begin
            tmr_r <= highCyc;
          end else if (tmrDone) begin
            sclOeN_r <= 1'b0;
            tmr_r <= lowCyc;
            if (bit_r == igc_pkg::BYTE_BITS) begin
              ackValid_r <= 1'b1;
              ackOk_r <= !sdaS;
              state_r <= stop_r ? igc_pkg::M_STOP1 : igc_pkg::M_WAIT;
            end else begin
              bit_r <= bit_r + 4'h1;
              byte_r <= {byte_r[6:0], 1'b0};
              state_r <= igc_pkg::M_LOW;
            end
          end
        end
        // low timer runs on so the next bit keeps its hold limit
        igc_pkg::M_WAIT: begin
          if (take) begin
            byte_r <= cmdByte;
            stop_r <= cmdStop;
            bit_r <= 4'h0;
            state_r <= cmdStart ? igc_pkg::M_RSSU : igc_pkg::M_LOW;
          end else begin
            cmdReady_r <= 1'b1;
          end
        end
        // scl high setup before repeated start
        igc_pkg::M_RSSU: begin
          if (!sclOeN_r) begin
            // finish the low phase so the slave has let go of sda
            if (tmrDone) begin
              sclOeN_r <= 1'b1;
              tmr_r <= suStaCyc;
            end
          end else if (!sclS) begin
            tmr_r <= suStaCyc;
          end else if (tmrDone) begin
            sdaOeN_r <= 1'b0;
            tmr_r <= hdStaCyc;
            state_r <= igc_pkg::M_START;
          end
        end
        igc_pkg::M_STOP1: begin
          if (tmr_r == dataAt) begin
            sdaOeN_r <= 1'b0;
          end
          if (tmrDone) begin
            sclOeN_r <= 1'b1;
            tmr_r <= suStoCyc;
            state_r <= igc_pkg::M_STOP2;
          end
        end
        igc_pkg::M_STOP2: begin
          if (!sclS) begin
            tmr_r <= suStoCyc;
          end else if (tmrDone) begin
            sdaOeN_r <= 1'b1;
            tmr_r <= bufCyc;
            state_r <= igc_pkg::M_BUF;
          end
        end
        default: begin
          state_r <= igc_pkg::M_IDLE;
        end
      endcase
    end
  end

  // outputs
  assign bus.mSclO = 1'b0;
  assign bus.mSdaO = 1'b0;
  assign bus.mSclOeN = sclOeN_r;
  assign bus.mSdaOeN = sdaOeN_r;
  assign cmdReady = cmdReady_r;
  assign ackValid = ackValid_r;
  assign ackOk = ackOk_r;
  assign busy = busy_r;

endmodule

// File: igc_bus_properties.sv
// timing checker for the shared two-wire bus lines
// assumes it sees the resolved lines of the bus interface on the system clock
`timescale 1ns/100ps
module igc_bus_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic fastMode,
  input wire logic scl,
  input wire logic sda
);
  localparam int CK = igc_pkg::CLK_NS;
  logic sclPrev_r, sdaPrev_r, first_r;
  logic [11:0] hi_r, lo_r, fall_r, stop_r, start_r;

  // least time in cycles for the selected mode
  function automatic logic [11:0] cyc(input logic fm, input int s, input int f);
    return 12'((fm ? f : s) / CK);
  endfunction

  // saturating increment
  function automatic logic [11:0] inc(input logic [11:0] v);
    return (v == 12'hFFF) ? v : v + 12'h001;
  endfunction

  // line events and mode limits
  wire logic startEv = sclPrev_r && scl && sdaPrev_r && !sda;
  wire logic stopEv = sclPrev_r && scl && !sdaPrev_r && sda;
  wire logic sclFall = sclPrev_r && !scl;
  wire logic [11:0] lowMin = cyc(fastMode, igc_pkg::SM_LOW_NS, igc_pkg::FM_LOW_NS);
  wire logic [11:0] highMin = cyc(fastMode, igc_pkg::SM_HIGH_NS, igc_pkg::FM_HIGH_NS);
  wire logic [11:0] perMin = cyc(fastMode, igc_pkg::SM_PERIOD_NS, igc_pkg::FM_PERIOD_NS);
  wire logic [11:0] bufMin = cyc(fastMode, igc_pkg::SM_BUF_NS, igc_pkg::FM_BUF_NS);
  wire logic [11:0] hdStaMin = cyc(fastMode, igc_pkg::SM_HDSTA_NS, igc_pkg::FM_HDSTA_NS);
  wire logic [11:0] suStaMin = cyc(fastMode, igc_pkg::SM_SUSTA_NS, igc_pkg::FM_SUSTA_NS);
  wire logic [11:0] suStoMin = cyc(fastMode, igc_pkg::SM_SUSTO_NS, igc_pkg::FM_SUSTO_NS);
  // one cycle of sampling lag allowed on the hold figure
  wire logic [11:0] holdMin = 12'(igc_pkg::HDDAT_NS / CK - 1);
  wire logic [11:0] holdMax = 12'(igc_pkg::FM_HDDAT_MAX_NS / CK);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // previous line levels
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclPrev_r <= scl;
      sdaPrev_r <= sda;
    end
  end

  // phase counters in cycles
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hi_r <= 12'h000;
      lo_r <= 12'h000;
      fall_r <= 12'hFFF;
    end else begin
      hi_r <= scl ? inc(hi_r) : 12'h000;
      lo_r <= scl ? 12'h000 : inc(lo_r);
      fall_r <= sclFall ? 12'h001 : inc(fall_r);
    end
  end

  // time since stop and since start
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stop_r <= 12'hFFF;
      start_r <= 12'hFFF;
      first_r <= 1'b0;
    end else begin
      stop_r <= stopEv ? 12'h001 : inc(stop_r);
      start_r <= startEv ? 12'h001 : inc(start_r);
      first_r <= startEv ? 1'b1 : (sclFall ? 1'b0 : first_r);
    end
  end

  property p_sclHigh;
    $fell(scl) |-> hi_r >= highMin;
  endproperty
  a_sclHigh: assert property (p_sclHigh) else $error("scl high too short");
  property p_sclLow;
    $rose(scl) |-> lo_r >= lowMin;
  endproperty
  a_sclLow: assert property (p_sclLow) else $error("scl low too short");
  property p_period;
    $fell(scl) |-> fall_r >= perMin;
  endproperty
  a_period: assert property (p_period) else $error("scl period too short");
  property p_busFree;
    startEv |-> stop_r >= bufMin;
  endproperty
  a_busFree: assert property (p_busFree) else $error("bus free too short");
  property p_hdSta;
    $fell(scl) && first_r |-> start_r >= hdStaMin;
  endproperty
  a_hdSta: assert property (p_hdSta) else $error("start hold too short");
  property p_suSta;
    startEv |-> hi_r >= suStaMin;
  endproperty
  a_suSta: assert property (p_suSta) else $error("start setup too short");
  property p_suSto;
    stopEv |-> hi_r >= suStoMin;
  endproperty
  a_suSto: assert property (p_suSto) else $error("stop setup too short");
  property p_hold;
    $changed(sda) && !scl && !$past(scl) |-> lo_r >= holdMin && (!fastMode || lo_r <= holdMax);
  endproperty
  a_hold: assert property (p_hold) else $error("data hold out of range");
endmodule

// File: i2c_general_call_and_bus_timing_test.sv
// bench joining master end and slave end over the shared bus
// assumes a 4 ns clock and the command and receive handshakes of both ends
`timescale 1ns/100ps
module i2c_general_call_and_bus_timing_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic fastMode = 1'b1;
  logic tenBit = 1'b1;
  logic [9:0] ownAddr = 10'h2C7;
  logic [7:0] txByte = 8'h3C;
  logic rxReady = 1'b0;
  logic cmdValid = 1'b0;
  logic [7:0] cmdByte = 8'h00;
  logic cmdStart = 1'b0;
  logic cmdStop = 1'b0;
  logic [7:0] rxData;
  logic rxValid, mstAddrValid, cmdReady, ackValid, ackOk, busy;
  logic [9:0] mstAddr;
  logic [9:0] gotAddr = 10'h000;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;

  igc_bus_if u_igc_bus_if ();
  igc_slave u_igc_slave (.clk(clk), .reset(reset), .bus(u_igc_bus_if.slave),
    .fastMode(fastMode), .tenBit(tenBit), .ownAddr(ownAddr), .txByte(txByte),
    .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady), .mstAddr(mstAddr),
    .mstAddrValid(mstAddrValid));
  igc_master u_igc_master (.clk(clk), .reset(reset), .bus(u_igc_bus_if.master),
    .fastMode(fastMode), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdByte(cmdByte),
    .cmdStart(cmdStart), .cmdStop(cmdStop), .ackValid(ackValid), .ackOk(ackOk), .busy(busy));
  igc_bus_properties u_igc_bus_properties (.clk(clk), .reset(reset), .fastMode(fastMode),
    .scl(u_igc_bus_if.scl), .sda(u_igc_bus_if.sda));

  always #2 clk = ~clk;

  // catch announced master address
  always @(negedge clk) begin
    if (mstAddrValid === 1'b1) begin
      gotAddr <= mstAddr;
    end
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 110000) begin
      n_mismatch++;
      $display("MISMATCH at %0t: timeout", $time);
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // bounded wait sampled at the falling edge
  task automatic waitLvl(ref logic s, input logic lvl);
    int n;
    n = 0;
    while (s !== lvl && n < 30000) begin
      @(negedge clk);
      n++;
    end
    if (s !== lvl) begin
      n_mismatch++;
      $display("MISMATCH at %0t: wait timed out", $time);
    end
  endtask

  // one byte command, then its acknowledge
  task automatic send(input logic [7:0] b, input logic st, input logic sp, input logic ack);
    waitLvl(cmdReady, 1'b1);
    cmdByte = b;
    cmdStart = st;
    cmdStop = sp;
    cmdValid = 1'b1;
    @(negedge clk);
    cmdValid = 1'b0;
    waitLvl(ackValid, 1'b1);
    chk({9'h000, ackOk}, {9'h000, ack}, "ack");
    @(negedge clk);
  endtask

  // pop one received byte
  task automatic pop(input logic [7:0] exp);
    waitLvl(rxValid, 1'b1);
    chk({1'b0, rxValid, rxData}, {2'h1, exp}, "rx data");
    rxReady = 1'b1;
    @(negedge clk);
    rxReady = 1'b0;
    @(negedge clk);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    // 10-bit write with a stalled receiver
    send(8'hF4, 1'b0, 1'b0, 1'b1);
    send(8'hC7, 1'b0, 1'b0, 1'b1);
    send(8'hD1, 1'b0, 1'b0, 1'b1);
    send(8'hD2, 1'b0, 1'b0, 1'b1);
    // third byte finds both buffer entries full
    fork
      send(8'hD3, 1'b0, 1'b1, 1'b1);
      begin
        waitLvl(u_igc_bus_if.sSclOeN, 1'b0);
        repeat (600) @(negedge clk);
        chk({9'h000, u_igc_bus_if.scl}, 10'h000, "stretch");
        pop(8'hD1);
      end
    join
    pop(8'hD2);
    pop(8'hD3);
    // general call with master address announce
    send(8'h00, 1'b0, 1'b0, 1'b1);
    send(8'h5B, 1'b0, 1'b0, 1'b1);
    send(8'h02, 1'b0, 1'b1, 1'b1);
    chk(gotAddr, 10'h25B, "master address");
    chk({9'h000, rxValid}, 10'h000, "announce not data");
    // start byte, then repeated starts
    send(8'h01, 1'b0, 1'b0, 1'b0);
    send(8'hF6, 1'b1, 1'b0, 1'b0);
    send(8'hF4, 1'b1, 1'b0, 1'b1);
    send(8'hC7, 1'b0, 1'b1, 1'b1);
    // standard mode transfer
    waitLvl(busy, 1'b0);
    fastMode = 1'b0;
    repeat (1000) @(negedge clk);
    send(8'hF4, 1'b0, 1'b1, 1'b1);
    waitLvl(busy, 1'b0);
    chk({9'h000, busy}, 10'h000, "idle after stop");
    chk({9'h000, rxValid}, 10'h000, "rx empty");
    end_of_test();
  end
endmodule
